//--- core/dos_pkg.sv
// Package: constants, register map and source bundle of the output source selector
package dos_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int MODE_W = 8;
    localparam int WARN_W = 16;
    localparam int PLC_W = 4;
    localparam int FBUS_W = 5;
    localparam int NUM_OUT = 4;
    localparam int STATE_W = 5;

    // ------------------------------------------------------------
    // Output indices
    // ------------------------------------------------------------
    localparam int IDX_OUT1 = 0;
    localparam int IDX_RELAY = 1;
    localparam int IDX_BIDIR = 2;
    localparam int IDX_MFO = 3;
    localparam int IDX_FAULT = 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE_OUT1 = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE_RELAY = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_MODE_BIDIR = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_MODE_MFO = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_MASK_GEN = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK_APP = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_FBUS_DOUT = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_APP_WARN = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_GEN_WARN = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_APP_SEEN = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_OUT_STATE = 6'h28;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
    localparam logic [WARN_W-1:0] MASK_RST = 16'h0000;
    localparam logic [FBUS_W-1:0] FBUS_RST = 5'h00;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_OFF = 8'h00;
    localparam logic [MODE_W-1:0] MODE_MOT_TEMP = 8'h13;
    localparam logic [MODE_W-1:0] MODE_GEN_MASK = 8'h19;
    localparam logic [MODE_W-1:0] MODE_APP_WARN = 8'h1A;
    localparam logic [MODE_W-1:0] MODE_APP_MASK = 8'h1B;
    localparam logic [MODE_W-1:0] MODE_ANY_WARN = 8'h1C;
    localparam logic [MODE_W-1:0] MODE_BOTH_MASK = 8'h1D;
    localparam logic [MODE_W-1:0] MODE_FLUX = 8'h1E;
    localparam logic [MODE_W-1:0] MODE_TRAVERSE = 8'h1F;
    localparam logic [MODE_W-1:0] MODE_BRAKE = 8'h29;
    localparam logic [MODE_W-1:0] MODE_EXT_FAN = 8'h2B;
    localparam logic [MODE_W-1:0] MODE_FAN_SVC = 8'h32;
    localparam logic [MODE_W-1:0] MODE_PLC_FIRST = 8'h50;
    localparam logic [MODE_W-1:0] MODE_PLC_LAST = 8'h53;
    localparam logic [MODE_W-1:0] MODE_FBUS_FIRST = 8'h5A;
    localparam logic [MODE_W-1:0] MODE_FBUS_LAST = 8'h5E;
    localparam logic [MODE_W-1:0] MODE_INV_FIRST = 8'h64;
    localparam logic [MODE_W-1:0] MODE_INV_LAST = 8'hC2;

    // ------------------------------------------------------------
    // Source bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic mot_temp_lim;
        logic gen_mask_res;
        logic app_warn_any;
        logic app_mask_res;
        logic gen_warn_any;
        logic flux_done;
        logic traverse_hs;
        logic brake_rel;
        logic ext_fan;
        logic fan_service;
        logic [PLC_W-1:0] plc;
        logic [FBUS_W-1:0] fbus;
    } dos_src_t;

endpackage

//--- core/dos_sync.sv
// Module: three-stage input synchroniser with agreement filter
module dos_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] s1_d, s2_d, s3_d, out_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s1_d = din;
        s2_d = s1_q;
        s3_d = s2_q;
        out_d = out_q;
        // Stage one is never looked at here, only copied
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else if (ce) begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;

endmodule // dos_sync

//--- core/dos_sel.sv
// Module: mode code decoder for one configurable output
module dos_sel (
    input wire logic [dos_pkg::MODE_W-1:0] mode,
    input wire dos_pkg::dos_src_t src,
    output logic level
);

    logic [dos_pkg::MODE_W-1:0] base;
    logic [dos_pkg::MODE_W-1:0] plc_ofs;
    logic [dos_pkg::MODE_W-1:0] fbus_ofs;
    logic inv;
    logic raw;

    always_comb begin
        base = mode;
        inv = 1'b0;
        if (mode >= dos_pkg::MODE_INV_FIRST && mode <= dos_pkg::MODE_INV_LAST) begin
            base = mode - dos_pkg::MODE_INV_FIRST;
            inv = 1'b1;
        end
        plc_ofs = base - dos_pkg::MODE_PLC_FIRST;
        fbus_ofs = base - dos_pkg::MODE_FBUS_FIRST;
        raw = 1'b0;
        case (base)
            dos_pkg::MODE_OFF: raw = 1'b0;
            dos_pkg::MODE_MOT_TEMP: raw = src.mot_temp_lim;
            dos_pkg::MODE_GEN_MASK: raw = src.gen_mask_res;
            dos_pkg::MODE_APP_WARN: raw = src.app_warn_any;
            dos_pkg::MODE_APP_MASK: raw = src.app_mask_res;
            dos_pkg::MODE_ANY_WARN: raw = src.gen_warn_any | src.app_warn_any;
            dos_pkg::MODE_BOTH_MASK: raw = src.gen_mask_res | src.app_mask_res;
            dos_pkg::MODE_FLUX: raw = src.flux_done;
            dos_pkg::MODE_TRAVERSE: raw = src.traverse_hs;
            dos_pkg::MODE_BRAKE: raw = src.brake_rel;
            dos_pkg::MODE_EXT_FAN: raw = src.ext_fan;
            dos_pkg::MODE_FAN_SVC: raw = src.fan_service;
            default: begin
                if (base >= dos_pkg::MODE_PLC_FIRST && base <= dos_pkg::MODE_PLC_LAST) begin
                    raw = src.plc[plc_ofs[1:0]];
                end else if (base >= dos_pkg::MODE_FBUS_FIRST && base <= dos_pkg::MODE_FBUS_LAST) begin
                    raw = src.fbus[fbus_ofs[2:0]];
                end else begin
                    // Unassigned base codes stay quiet unless inverted, where the level goes high
                    raw = 1'b0;
                end
            end
        endcase
        level = raw ^ inv;
    end

endmodule // dos_sel

//--- core/dos_top.sv
// Module: digital output source selector with Avalon-MM register slave
//
// Design decisions made here: the address map and the Avalon-MM slave port.
module dos_top (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [dos_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [dos_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [dos_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [dos_pkg::WARN_W-1:0] WARN_GEN,
    input wire logic [dos_pkg::WARN_W-1:0] WARN_APP,
    input wire logic MOT_TEMP_LIMIT,
    input wire logic FLUX_DONE,
    input wire logic TRAVERSE_HANDSHAKE,
    input wire logic BRAKE_RELEASE,
    input wire logic FAN_TEMP_REACHED,
    input wire logic FAN_SERVICE_EXPIRED,
    input wire logic [dos_pkg::PLC_W-1:0] PLC_OUT_BUF,
    input wire logic COMM_FAULT,
    output logic DIGITAL_OUT_ONE,
    output logic RELAY_OUT_TWO,
    output logic BIDIR_OUT_THREE,
    output logic MULTIFUNCTION_OUT_ONE
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [dos_pkg::MODE_W-1:0] mode_q [dos_pkg::NUM_OUT];
    logic [dos_pkg::MODE_W-1:0] mode_d [dos_pkg::NUM_OUT];
    logic [dos_pkg::WARN_W-1:0] mask_gen_q, mask_gen_d;
    logic [dos_pkg::WARN_W-1:0] mask_app_q, mask_app_d;
    logic [dos_pkg::WARN_W-1:0] app_seen_q, app_seen_d;
    logic [dos_pkg::FBUS_W-1:0] fbus_q, fbus_d;
    logic [dos_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic wreq_q, wreq_d;
    logic [dos_pkg::NUM_OUT-1:0] out_q, out_d;
    logic [dos_pkg::NUM_OUT-1:0] level;
    logic [dos_pkg::DATA_W-1:0] rd_word;
    logic [dos_pkg::ADDR_W-1:0] mode_ofs [dos_pkg::NUM_OUT];
    logic [dos_pkg::STATE_W-1:0] out_state;
    logic req;
    logic wr_go;
    logic rd_go;
    logic comm_fault_s;
    dos_pkg::dos_src_t src;

    assign mode_ofs[dos_pkg::IDX_OUT1] = dos_pkg::OFS_MODE_OUT1;
    assign mode_ofs[dos_pkg::IDX_RELAY] = dos_pkg::OFS_MODE_RELAY;
    assign mode_ofs[dos_pkg::IDX_BIDIR] = dos_pkg::OFS_MODE_BIDIR;
    assign mode_ofs[dos_pkg::IDX_MFO] = dos_pkg::OFS_MODE_MFO;

    // ------------------------------------------------------------
    // Fault input from the power section
    // ------------------------------------------------------------
    // Arrives from another board domain, so it is filtered
    dos_sync #(
        .W(1)
    ) u_fault_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .ce(CE),
        .din(COMM_FAULT),
        .dout(comm_fault_s)
    );

    // ------------------------------------------------------------
    // Source bundle
    // ------------------------------------------------------------
    // Status inputs come from logic on this clock: no synchroniser
    always_comb begin
        src.mot_temp_lim = MOT_TEMP_LIMIT;
        src.gen_warn_any = |WARN_GEN;
        src.app_warn_any = |WARN_APP;
        src.gen_mask_res = |(WARN_GEN & mask_gen_q);
        src.app_mask_res = |(WARN_APP & mask_app_q);
        src.flux_done = FLUX_DONE;
        src.traverse_hs = TRAVERSE_HANDSHAKE;
        src.brake_rel = BRAKE_RELEASE;
        src.ext_fan = FAN_TEMP_REACHED;
        src.fan_service = FAN_SERVICE_EXPIRED;
        src.plc = PLC_OUT_BUF;
        src.fbus = fbus_q;
    end

    // ------------------------------------------------------------
    // Per-output decoders
    // ------------------------------------------------------------
    for (genvar g = 0; g < dos_pkg::NUM_OUT; g++) begin : g_sel
        dos_sel u_sel (
            .mode(mode_q[g]),
            .src(src),
            .level(level[g])
        );
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_comb begin
        out_d = level;
        if (comm_fault_s) begin
            out_d[dos_pkg::IDX_RELAY] = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            out_q <= '0;
        end else if (CE) begin
            out_q <= out_d;
        end
    end

    assign DIGITAL_OUT_ONE = out_q[dos_pkg::IDX_OUT1];
    assign RELAY_OUT_TWO = out_q[dos_pkg::IDX_RELAY];
    assign BIDIR_OUT_THREE = out_q[dos_pkg::IDX_BIDIR];
    assign MULTIFUNCTION_OUT_ONE = out_q[dos_pkg::IDX_MFO];

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Waitrequest idles high; one low cycle completes each access
    assign req = AVS_READ | AVS_WRITE;
    assign wr_go = AVS_WRITE & ~wreq_q;
    assign rd_go = AVS_READ & wreq_q;
    assign out_state = {comm_fault_s, out_q};

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        for (int i = 0; i < dos_pkg::NUM_OUT; i++) begin
            if (AVS_ADDRESS == mode_ofs[i]) begin
                rd_word[dos_pkg::MODE_W-1:0] = mode_q[i];
            end
        end
        case (AVS_ADDRESS)
            dos_pkg::OFS_MASK_GEN: rd_word[dos_pkg::WARN_W-1:0] = mask_gen_q;
            dos_pkg::OFS_MASK_APP: rd_word[dos_pkg::WARN_W-1:0] = mask_app_q;
            dos_pkg::OFS_FBUS_DOUT: rd_word[dos_pkg::FBUS_W-1:0] = fbus_q;
            dos_pkg::OFS_APP_WARN: rd_word[dos_pkg::WARN_W-1:0] = WARN_APP;
            dos_pkg::OFS_GEN_WARN: rd_word[dos_pkg::WARN_W-1:0] = WARN_GEN;
            dos_pkg::OFS_APP_SEEN: rd_word[dos_pkg::WARN_W-1:0] = app_seen_q;
            dos_pkg::OFS_OUT_STATE: rd_word[dos_pkg::STATE_W-1:0] = out_state;
            default: begin
                // Unmapped and mode offsets fall through here
                rd_word = rd_word;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        mask_gen_d = mask_gen_q;
        mask_app_d = mask_app_q;
        fbus_d = fbus_q;
        rdata_d = rdata_q;
        wreq_d = ~(req & wreq_q);
        if (rd_go) begin
            rdata_d = rd_word;
        end
        // Writes land at the edge where waitrequest is seen low
        if (wr_go) begin
            for (int i = 0; i < dos_pkg::NUM_OUT; i++) begin
                if (AVS_ADDRESS == mode_ofs[i] && AVS_BYTEENABLE[0]) begin
                    mode_d[i] = AVS_WRITEDATA[dos_pkg::MODE_W-1:0];
                end
            end
            case (AVS_ADDRESS)
                dos_pkg::OFS_MASK_GEN: begin
                    if (AVS_BYTEENABLE[0]) begin
                        mask_gen_d[7:0] = AVS_WRITEDATA[7:0];
                    end
                    if (AVS_BYTEENABLE[1]) begin
                        mask_gen_d[15:8] = AVS_WRITEDATA[15:8];
                    end
                end
                dos_pkg::OFS_MASK_APP: begin
                    if (AVS_BYTEENABLE[0]) begin
                        mask_app_d[7:0] = AVS_WRITEDATA[7:0];
                    end
                    if (AVS_BYTEENABLE[1]) begin
                        mask_app_d[15:8] = AVS_WRITEDATA[15:8];
                    end
                end
                dos_pkg::OFS_FBUS_DOUT: begin
                    if (AVS_BYTEENABLE[0]) begin
                        fbus_d = AVS_WRITEDATA[dos_pkg::FBUS_W-1:0];
                    end
                end
                default: begin
                    // Read-only and unmapped offsets ignore writes
                    fbus_d = fbus_d;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sticky application warning history
    // ------------------------------------------------------------
    // Write one to clear; a warning present in the same cycle stays set
    always_comb begin
        app_seen_d = app_seen_q;
        if (wr_go && AVS_ADDRESS == dos_pkg::OFS_APP_SEEN) begin
            if (AVS_BYTEENABLE[0]) begin
                app_seen_d[7:0] = app_seen_q[7:0] & ~AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
                app_seen_d[15:8] = app_seen_q[15:8] & ~AVS_WRITEDATA[15:8];
            end
        end
        app_seen_d = app_seen_d | WARN_APP;
    end

    // ------------------------------------------------------------
    // Register file storage
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            for (int i = 0; i < dos_pkg::NUM_OUT; i++) begin
                mode_q[i] <= dos_pkg::MODE_RST;
            end
            mask_gen_q <= dos_pkg::MASK_RST;
            mask_app_q <= dos_pkg::MASK_RST;
            app_seen_q <= dos_pkg::MASK_RST;
            fbus_q <= dos_pkg::FBUS_RST;
            rdata_q <= '0;
            wreq_q <= 1'b1;
        end else if (CE) begin
            mode_q <= mode_d;
            mask_gen_q <= mask_gen_d;
            mask_app_q <= mask_app_d;
            app_seen_q <= app_seen_d;
            fbus_q <= fbus_d;
            rdata_q <= rdata_d;
            wreq_q <= wreq_d;
        end
    end

    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wreq_q;

endmodule // dos_top

//--- tb/dos_term.sv
// Partner model: output terminals as seen by external relays and loads
module dos_term (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] drive,
    output logic [3:0] term
);
    timeunit 1ns;
    timeprecision 1ns;
    // Loads take the terminal level once a clock; reset opens every contact
    always_ff @(posedge clk) begin
        if (rst) begin
            term <= 4'h0;
        end else begin
            term <= drive;
        end
    end
endmodule // dos_term

//--- tb/dos_chk_sva.sv
// Checker: port assertions of the output source selector
module dos_chk (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [dos_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [dos_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [dos_pkg::WARN_W-1:0] WARN_GEN,
    input wire logic [dos_pkg::WARN_W-1:0] WARN_APP,
    input wire logic FLUX_DONE,
    input wire logic [dos_pkg::PLC_W-1:0] PLC_OUT_BUF,
    input wire logic COMM_FAULT,
    input wire logic DIGITAL_OUT_ONE,
    input wire logic RELAY_OUT_TWO,
    input wire logic BIDIR_OUT_THREE,
    input wire logic MULTIFUNCTION_OUT_ONE
);
    timeunit 1ns;
    timeprecision 1ns;
    // Shadow of the four mode codes, taken from committed bus writes
    logic [7:0] m_q [4];
    logic [7:0] m_d [4];
    wire logic plc_sel = PLC_OUT_BUF[m_q[2][1:0]];
    wire logic app_any = |WARN_APP;
    wire logic any_warn = (|WARN_GEN) || (|WARN_APP);
    always_comb begin
        m_d = m_q;
        if (CE && AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[5:4] == 2'h0 && AVS_ADDRESS[1:0] == 2'h0) begin
            m_d[AVS_ADDRESS[3:2]] = AVS_WRITEDATA[7:0];
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            m_q <= '{default: 8'h00};
        end else begin
            m_q <= m_d;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    sequence acc_s;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE;
    endsequence
    sequence one_wait_s;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    bus_wait_a: assert property (acc_s |=> one_wait_s)
        else $error("wait state not one cycle");
    off_out_a: assert property (m_q[0] == 8'h00 && CE |=> !DIGITAL_OUT_ONE)
        else $error("output on in off mode");
    flux_out_a: assert property (m_q[0] == 8'h1E && CE |=> DIGITAL_OUT_ONE == $past(FLUX_DONE))
        else $error("flux output wrong");
    inv_flux_a: assert property (m_q[0] == 8'h82 && CE |=> DIGITAL_OUT_ONE != $past(FLUX_DONE))
        else $error("inverted output wrong");
    app_warn_a: assert property (m_q[2] == 8'h1A && CE |=> BIDIR_OUT_THREE == $past(app_any))
        else $error("application warning output wrong");
    plc_out_a: assert property (m_q[2] inside {[8'h50:8'h53]} && CE |=> BIDIR_OUT_THREE == $past(plc_sel))
        else $error("logic buffer output wrong");
    // Fault must be gone long enough to have left the synchroniser
    any_warn_a: assert property ((!COMM_FAULT && CE) [*5] ##0 (m_q[1] == 8'h1C) |=> RELAY_OUT_TWO == $past(any_warn))
        else $error("any warning output wrong");
    relay_off_a: assert property ((COMM_FAULT && CE) [*7] |=> !RELAY_OUT_TWO)
        else $error("relay on during fault");
endmodule // dos_chk
bind dos_top dos_chk dos_chk_i (.CLK_SYS, .SYS_RST, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_WAITREQUEST, .WARN_GEN, .WARN_APP, .FLUX_DONE, .PLC_OUT_BUF, .COMM_FAULT, .DIGITAL_OUT_ONE,
    .RELAY_OUT_TWO, .BIDIR_OUT_THREE, .MULTIFUNCTION_OUT_ONE);

//--- tb/tb.sv
// Testbench: output source selector driven over the register bus
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic [15:0] warn_gen = 16'h0;
    logic [15:0] warn_app = 16'h0;
    logic [5:0] srcv = 6'h00;
    logic [3:0] plc = 4'h0;
    logic fault = 1'b0;
    logic ce = 1'b1;
    wire logic [3:0] outs;
    logic [3:0] term;
    int fails = 0;
    int comparisons = 0;
    always #25 clk_sys = ~clk_sys;
    dos_top dos_top_i (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(ce), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .WARN_GEN(warn_gen), .WARN_APP(warn_app), .MOT_TEMP_LIMIT(srcv[0]),
        .FLUX_DONE(srcv[1]), .TRAVERSE_HANDSHAKE(srcv[2]), .BRAKE_RELEASE(srcv[3]), .FAN_TEMP_REACHED(srcv[4]),
        .FAN_SERVICE_EXPIRED(srcv[5]), .PLC_OUT_BUF(plc), .COMM_FAULT(fault), .DIGITAL_OUT_ONE(outs[0]),
        .RELAY_OUT_TWO(outs[1]), .BIDIR_OUT_THREE(outs[2]), .MULTIFUNCTION_OUT_ONE(outs[3]));
    dos_term dos_term_i (.clk(clk_sys), .rst(sys_rst), .drive(outs), .term(term));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held up to the edge that sees waitrequest low; data taken and request dropped there
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        while (wait_req !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        chk("waitrequest", 32'h0, {31'h0, wait_req});
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rreg(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk($sformatf("register %h", a), e, q);
    endtask
    task automatic ochk(input logic [3:0] m, input logic [3:0] e);
        repeat (4) @(posedge clk_sys);
        chk("terminals", {28'h0, e}, {28'h0, term & m});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int a = 0; a < 52; a += 4) begin
            rreg(6'(a), 32'h0);
        end
        ochk(4'hF, 4'h0);
    endtask
    task automatic t_single();
        logic [7:0] c [6] = '{8'h13, 8'h1E, 8'h1F, 8'h29, 8'h2B, 8'h32};
        for (int i = 0; i < 6; i++) begin
            wreg(dos_pkg::OFS_MODE_OUT1, {24'h0, c[i]});
            srcv <= ~(6'h01 << i);
            ochk(4'hF, 4'h0);
            srcv <= 6'h01 << i;
            ochk(4'hF, 4'h1);
            wreg(dos_pkg::OFS_MODE_OUT1, {24'h0, c[i] + 8'h64});
            ochk(4'hF, 4'h0);
        end
        wreg(dos_pkg::OFS_MODE_OUT1, 32'h0);
    endtask
    task automatic t_route();
        for (int k = 0; k < 4; k++) begin
            wreg(dos_pkg::OFS_MODE_BIDIR, 32'h50 + k);
            plc <= ~(4'h1 << k);
            ochk(4'h4, 4'h0);
            plc <= 4'h1 << k;
            ochk(4'h4, 4'h4);
        end
        for (int k = 0; k < 5; k++) begin
            wreg(dos_pkg::OFS_FBUS_DOUT, 32'h1 << k);
            wreg(dos_pkg::OFS_MODE_MFO, 32'h5A + k);
            ochk(4'h8, 4'h8);
            wreg(dos_pkg::OFS_FBUS_DOUT, ~(32'h1 << k) & 32'h1F);
            ochk(4'h8, 4'h0);
            rreg(dos_pkg::OFS_FBUS_DOUT, ~(32'h1 << k) & 32'h1F);
        end
    endtask
    task automatic t_warn();
        logic [15:0] g [4] = '{16'h0001, 16'h0010, 16'h0000, 16'h0000};
        logic [15:0] p [4] = '{16'h0000, 16'h0000, 16'h0002, 16'h0100};
        logic [3:0] e [4] = '{4'h2, 4'h3, 4'h6, 4'hE};
        wreg(dos_pkg::OFS_MASK_GEN, 32'h0010);
        wreg(dos_pkg::OFS_MASK_APP, 32'h0100);
        wreg(dos_pkg::OFS_MODE_OUT1, 32'h19);
        wreg(dos_pkg::OFS_MODE_RELAY, 32'h1C);
        wreg(dos_pkg::OFS_MODE_BIDIR, 32'h1A);
        wreg(dos_pkg::OFS_MODE_MFO, 32'h1B);
        for (int i = 0; i < 4; i++) begin
            warn_gen <= g[i];
            warn_app <= p[i];
            ochk(4'hF, e[i]);
            rreg(dos_pkg::OFS_APP_WARN, {16'h0, p[i]});
        end
        wreg(dos_pkg::OFS_APP_WARN, 32'hFFFF);
        rreg(dos_pkg::OFS_APP_WARN, 32'h0100);
        rreg(dos_pkg::OFS_APP_SEEN, 32'h0102);
        wreg(dos_pkg::OFS_APP_SEEN, 32'hFFFF);
        rreg(dos_pkg::OFS_APP_SEEN, 32'h0100);
        wreg(dos_pkg::OFS_MODE_OUT1, 32'h1D);
        ochk(4'h1, 4'h1);
        warn_gen <= 16'h0001;
        warn_app <= 16'h0002;
        ochk(4'h1, 4'h0);
        warn_gen <= 16'h0010;
        ochk(4'h1, 4'h1);
        warn_gen <= 16'h0000;
        warn_app <= 16'h0000;
    endtask
    task automatic t_fault();
        wreg(dos_pkg::OFS_MODE_OUT1, 32'h64);
        wreg(dos_pkg::OFS_MODE_RELAY, 32'h64);
        ochk(4'h3, 4'h3);
        fault <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ochk(4'h3, 4'h1);
        rreg(dos_pkg::OFS_OUT_STATE, 32'h11);
        fault <= 1'b0;
        repeat (8) @(posedge clk_sys);
        ochk(4'h3, 4'h3);
    endtask
    task automatic t_hold();
        wreg(dos_pkg::OFS_MODE_OUT1, 32'h1E);
        srcv <= 6'h02;
        ochk(4'h1, 4'h1);
        ce <= 1'b0;
        srcv <= 6'h00;
        ochk(4'h1, 4'h1);
        ce <= 1'b1;
        ochk(4'h1, 4'h0);
    endtask
    task automatic end_sim();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_single();
        t_route();
        t_warn();
        t_fault();
        t_hold();
        end_sim();
    end
    // Whole run needs about 430 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        end_sim();
    end
endmodule // tb
